// File: fault_map.svh
`ifndef FAULT_MAP_SVH
`define FAULT_MAP_SVH
// consecutive-cycle trip counts
`define OV_TRIP_CYCLES 2'h3
`define SAT_TRIP_CYCLES 2'h3
`define BULK_TRIP_CYCLES 2'h3
`define CNT_ZERO 2'h0
`define CNT_ONE 2'h1
// thermal trip and hysteresis in degrees C
`define THERMAL_TRIP_DEG 130
`define THERMAL_HYST_DEG 30
// register offsets (byte addresses)
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_CAUSE 4'h8
// ctrl field positions
`define CTRL_EN_BIT 0
`define CTRL_FORCE_BIT 1
`define CTRL_RESET_VAL 2'h1
`endif

// File: fault_pkg.sv
package fault_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_DISCHARGE = 3'h1,
    ST_CHARGE = 3'h2,
    ST_PROBE = 3'h3,
    ST_PROBE_WAIT = 3'h4
  } rec_state_e;
  typedef logic [1:0] cnt_t;
endpackage : fault_pkg

// File: consec_counter.sv
`timescale 1ns/1ps
`include "fault_map.svh"
// counts successive switching cycles that show a fault condition
module consec_counter
  import fault_pkg::*;
#(
  parameter cnt_t LIMIT = `OV_TRIP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic cycle_end_i,
  input wire logic cond_i,
  output logic trip_o
);
  cnt_t cnt_r;
  // restart wipes history; a clean cycle wipes it too
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      cnt_r <= `CNT_ZERO;
    end else if (cycle_end_i) begin
      if (!cond_i) begin
        cnt_r <= `CNT_ZERO;
      end else if (cnt_r != LIMIT) begin
        cnt_r <= cnt_r + `CNT_ONE;
      end
    end
  end
  assign trip_o = (cnt_r == LIMIT);
  a_cnt_clean: assert property (@(posedge clk_i) disable iff (rst_i)
    cycle_end_i && !cond_i && !clear_i |=> cnt_r == `CNT_ZERO)
    else $error("counter not cleared by clean cycle");
endmodule : consec_counter

// File: flyback_fault_manager.sv
`timescale 1ns/1ps
`include "fault_map.svh"
// Contract
// - most faults enter auto-recovery, restart by itself
// - supply overvoltage blocks drive at once
// - output overvoltage three cycles then recovery
// - three saturated pulses stop switching, recovery
// - thermal trip stops switching immediately
// - after thermal trip wait thirty degree hysteresis
// - sample bus indication during primary conduction
// - bus low three cycles then recovery
// - one probe pulse after bulk-open restart
// - probe above recover threshold resumes switching
// - probe not above threshold stops again
// - compensation switch closed only while primary conducts
module flyback_fault_manager
  import fault_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pwm_req_i,
  input wire logic supply_ov_i,
  input wire logic fb_ov_i,
  input wire logic sat_i,
  input wire logic hot_i,
  input wire logic cool_i,
  input wire logic bus_low_i,
  input wire logic bus_high_i,
  input wire logic supply_min_i,
  input wire logic supply_start_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic gate_o,
  output logic comp_sw_o,
  output logic [2:0] state_o
);
  // two-stage synchronisers for analog comparator pins
  logic [10:0] s1_r;
  logic [10:0] s2_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= 11'h000;
      s2_r <= 11'h000;
    end else begin
      s1_r <= {pwm_req_i, supply_ov_i, fb_ov_i, sat_i, hot_i, cool_i,
               bus_low_i, bus_high_i, supply_min_i, supply_start_i,
               1'b0};
      s2_r <= s1_r;
    end
  end
  logic pwm_s, sov_s, fbov_s, sat_s, hot_s, cool_s;
  logic blow_s, bhigh_s, smin_s, sstart_s;
  assign {pwm_s, sov_s, fbov_s, sat_s, hot_s, cool_s,
          blow_s, bhigh_s, smin_s, sstart_s} = s2_r[10:1];

  rec_state_e state_r;
  logic [1:0] ctrl_r;
  logic thermal_r;
  logic bulk_r;
  logic [3:0] cause_r;
  logic gate_r;
  logic pwm_d_r;
  logic bus_low_smp_r;
  logic sat_seen_r;
  logic probe_hi_r;
  logic restart;
  logic cycle_end;
  logic ov_trip, sat_trip, bulk_trip;
  logic any_fault;
  logic drive_ok;
  logic drive_state;

  // a cycle ends when the drive request falls
  assign cycle_end = pwm_d_r && !pwm_s;
  assign restart = (state_r == ST_CHARGE) && sstart_s;
  assign drive_ok = ctrl_r[`CTRL_EN_BIT] && !sov_s && !hot_s;
  // only the run and probe states may pass a drive request through
  assign drive_state = (state_r == ST_RUN) || (state_r == ST_PROBE);

  // previous request level for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_d_r <= 1'b0;
    end else begin
      pwm_d_r <= pwm_s;
    end
  end

  // bus level and saturation are captured while the switch conducts
  always_ff @(posedge clk_i) begin
    if (rst_i || cycle_end) begin
      bus_low_smp_r <= 1'b0;
      sat_seen_r <= 1'b0;
    end else if (gate_r) begin
      bus_low_smp_r <= bus_low_smp_r | blow_s;
      sat_seen_r <= sat_seen_r | sat_s;
    end
  end

  // probe result must outlive the pulse end: the verdict is taken one
  // cycle after it, so this flag clears on restart, not on cycle end
  always_ff @(posedge clk_i) begin
    if (rst_i || restart) begin
      probe_hi_r <= 1'b0;
    end else if (gate_r && state_r == ST_PROBE) begin
      probe_hi_r <= probe_hi_r | bhigh_s;
    end
  end

  consec_counter #(.LIMIT(`OV_TRIP_CYCLES)) u_ov (
    .clk_i(clk_i), .rst_i(rst_i), .clear_i(restart),
    .cycle_end_i(cycle_end), .cond_i(fbov_s), .trip_o(ov_trip));
  consec_counter #(.LIMIT(`SAT_TRIP_CYCLES)) u_sat (
    .clk_i(clk_i), .rst_i(rst_i), .clear_i(restart),
    .cycle_end_i(cycle_end), .cond_i(sat_seen_r),
    .trip_o(sat_trip));
  consec_counter #(.LIMIT(`BULK_TRIP_CYCLES)) u_bulk (
    .clk_i(clk_i), .rst_i(rst_i), .clear_i(restart),
    .cycle_end_i(cycle_end), .cond_i(bus_low_smp_r),
    .trip_o(bulk_trip));

  assign any_fault = sov_s || hot_s || ov_trip || sat_trip || bulk_trip ||
                     ctrl_r[`CTRL_FORCE_BIT];

  // thermal latch holds until the cool comparator reports hysteresis
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thermal_r <= 1'b0;
    end else if (hot_s) begin
      thermal_r <= 1'b1;
    end else if (cool_s) begin
      thermal_r <= 1'b0;
    end
  end

  // recovery sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_RUN;
      bulk_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_RUN: begin
          if (any_fault) begin
            state_r <= ST_DISCHARGE;
            bulk_r <= bulk_trip;
          end
        end
        ST_DISCHARGE: begin
          if (smin_s) begin
            state_r <= ST_CHARGE;
          end
        end
        ST_CHARGE: begin
          if (sstart_s && !thermal_r && !sov_s) begin
            state_r <= bulk_r ? ST_PROBE : ST_RUN;
          end
        end
        ST_PROBE: begin
          if (cycle_end) begin
            state_r <= ST_PROBE_WAIT;
          end
        end
        ST_PROBE_WAIT: begin
          if (probe_hi_r) begin
            state_r <= ST_RUN;
            bulk_r <= 1'b0;
          end else begin
            state_r <= ST_DISCHARGE;
          end
        end
      endcase
    end
  end

  // gate drive; overvoltage and heat cut it mid-pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_r <= 1'b0;
    end else if (!drive_ok || any_fault) begin
      gate_r <= 1'b0;
    end else if (state_r == ST_RUN || state_r == ST_PROBE) begin
      gate_r <= pwm_s;
    end else begin
      gate_r <= 1'b0;
    end
  end
  assign gate_o = gate_r;

  // compensation switch mirrors conduction interval
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comp_sw_o <= 1'b0;
    end else begin
      // a fault that cuts the gate must open the switch in the same cycle
      comp_sw_o <= gate_r && pwm_s && drive_ok && !any_fault &&
                   drive_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_o <= 3'h0;
    end else begin
      state_o <= state_r;
    end
  end

  // sticky cause bits; a new fault wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_r <= 4'h0;
    end else begin
      cause_r <= ((wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
                   wb_adr_i == `REG_CAUSE && wb_sel_i[0]) ?
                  (cause_r & ~wb_dat_i[3:0]) : cause_r) |
                 {bulk_trip, sat_trip, ov_trip, sov_s | hot_s};
    end
  end

  // wishbone classic slave, one wait state, ack for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_r <= `CTRL_RESET_VAL;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        if (wb_we_i && wb_adr_i == `REG_CTRL && wb_sel_i[0]) begin
          ctrl_r <= wb_dat_i[1:0];
        end
        unique case (wb_adr_i)
          `REG_CTRL: wb_dat_o <= {30'h0, ctrl_r};
          `REG_STATUS: wb_dat_o <= {26'h0, thermal_r, bulk_r, gate_r,
                                    state_r};
          `REG_CAUSE: wb_dat_o <= {28'h0, cause_r};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  a_ov_blocks_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    sov_s |=> !gate_r)
    else $error("gate high after supply overvoltage");
  a_hot_blocks_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    hot_s |=> !gate_r)
    else $error("gate high after thermal trip");
  a_fault_recovers: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == ST_RUN && any_fault |=> state_r == ST_DISCHARGE)
    else $error("fault did not enter recovery");
  a_wait_min: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == ST_DISCHARGE && !smin_s |=> state_r == ST_DISCHARGE)
    else $error("left discharge before minimum supply");
  a_thermal_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == ST_CHARGE && thermal_r |=> state_r != ST_RUN)
    else $error("restart during thermal hysteresis");
  a_probe_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == ST_PROBE_WAIT && probe_hi_r |=> state_r == ST_RUN)
    else $error("good probe did not resume");
  a_probe_fail: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == ST_PROBE_WAIT && !probe_hi_r |=>
    state_r == ST_DISCHARGE)
    else $error("bad probe did not stop");
  a_bulk_probe: assert property (@(posedge clk_i) disable iff (rst_i)
    restart && bulk_r && !thermal_r && !sov_s |=> state_r == ST_PROBE)
    else $error("no probe after bulk fault");
  a_comp_sw: assert property (@(posedge clk_i) disable iff (rst_i)
    comp_sw_o |-> $past(gate_r))
    else $error("compensation switch outside conduction");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_comp_in_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    comp_sw_o |-> gate_r)
    else $error("compensation switch closed with gate off");
  a_gate_states: assert property (@(posedge clk_i) disable iff (rst_i)
    gate_r |-> $past(drive_state))
    else $error("gate driven outside run or probe");
  a_probe_single: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == ST_PROBE && cycle_end |=> state_r == ST_PROBE_WAIT)
    else $error("probe did not end after one pulse");
  c_probe_fail: cover property (@(posedge clk_i) disable iff (rst_i)
    state_r == ST_PROBE_WAIT && !probe_hi_r);
  c_ov_trip: cover property (@(posedge clk_i) disable iff (rst_i) ov_trip);
  c_sat_trip: cover property (@(posedge clk_i) disable iff (rst_i)
    sat_trip);
  c_probe_ok: cover property (@(posedge clk_i) disable iff (rst_i)
    state_r == ST_PROBE_WAIT && probe_hi_r);
  c_thermal: cover property (@(posedge clk_i) disable iff (rst_i)
    thermal_r && state_r == ST_CHARGE);
endmodule : flyback_fault_manager

// File: stage_model.sv
`timescale 1ns/1ps
// supply rail and aux winding of the power stage
module stage_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic gate_i,
  input wire logic bus_ok_i,
  output logic supply_min_o,
  output logic supply_start_o,
  output logic bus_low_o,
  output logic bus_high_o
);
  logic [5:0] idle_r;
  logic [4:0] sup_r;
  logic chg_r;
  // aux winding feeds the rail only while switching; without it the
  // rail sags to the minimum, then the start-up path recharges it
  always_ff @(posedge clk_i) begin
    if (rst_i || gate_i) begin
      idle_r <= 6'h00;
      sup_r <= 5'h14;
      chg_r <= 1'h0;
    end else if (chg_r) begin
      sup_r <= sup_r + 5'h01;
      if (sup_r == 5'h0F) begin
        chg_r <= 1'h0;
        idle_r <= 6'h00;
      end
    end else if (idle_r != 6'h20) begin
      idle_r <= idle_r + 6'h01;
    end else if (sup_r == 5'h00) begin
      chg_r <= 1'h1;
    end else begin
      sup_r <= sup_r - 5'h01;
    end
  end
  // comparator levels seen by the controller
  assign supply_min_o = (sup_r == 5'h00);
  assign supply_start_o = (sup_r >= 5'h10);
  assign bus_low_o = !bus_ok_i;
  assign bus_high_o = bus_ok_i;
endmodule : stage_model

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic pwm_req_i = 1'h0;
  logic pwm_en = 1'h0;
  logic [3:0] ph = 4'h0;
  logic [4:0] flt = 5'h00;
  logic cool_i = 1'h0;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, gate_o, comp_sw_o, s_min, s_start, b_low, b_high;
  logic gate_q = 1'h0;
  logic [2:0] state_o;
  int rises = 0;
  int err_total = 0;
  int checks_done = 0;
  int b;
  always #5 clk_i = ~clk_i;
  stage_model stage_u (.clk_i(clk_i), .rst_i(rst_i), .gate_i(gate_o),
    .bus_ok_i(!flt[4]), .supply_min_o(s_min), .supply_start_o(s_start),
    .bus_low_o(b_low), .bus_high_o(b_high));
  flyback_fault_manager dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .pwm_req_i(pwm_req_i), .supply_ov_i(flt[2]), .fb_ov_i(flt[0]),
    .sat_i(flt[1]), .hot_i(flt[3]), .cool_i(cool_i), .bus_low_i(b_low),
    .bus_high_i(b_high), .supply_min_i(s_min), .supply_start_i(s_start),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .gate_o(gate_o),
    .comp_sw_o(comp_sw_o), .state_o(state_o));
  // loop requests: 8 on, 8 off, short enough that the rail never sags
  always @(posedge clk_i) begin
    ph <= ph + 4'h1;
    pwm_req_i <= pwm_en && (ph < 4'h8);
    gate_q <= gate_o;
    if (gate_o && !gate_q) rises <= rises + 1;
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [3:0] a,
                    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'h1 && k < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : wb
  task automatic edge_wait(input logic lvl);
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (!(gate_o === lvl && gate_q === !lvl) && k < 100);
  endtask : edge_wait
  task automatic wait_st(input logic [2:0] s, input int lim);
    int k;
    k = 0;
    while (state_o !== s && k < lim) begin
      @(posedge clk_i);
      k++;
    end
    chk("state", {29'h0, s}, {29'h0, state_o});
  endtask : wait_st
  task automatic cause(input logic [31:0] c);
    wb(1'h0, 4'h8, 32'h0);
    chk("cause", c, rd);
    wb(1'h1, 4'h8, c);
  endtask : cause
  // fault armed at a pulse end; n == 6 puts one clean cycle inside
  task automatic trip(input logic [4:0] m, input int n,
                      input logic [31:0] c);
    edge_wait(1'h0);
    flt <= m;
    b = rises;
    if (n == 6) begin
      repeat (2) edge_wait(1'h0);
      flt <= 5'h00;
      edge_wait(1'h0);
      flt <= m;
    end
    wait_st(3'h1, 400);
    chk("pulses", n, rises - b);
    flt <= 5'h00;
    wait_st(3'h0, 400);
    cause(c);
  endtask : trip
  // fault raised in mid-pulse must cut the drive before the pulse ends
  task automatic mid(input logic [4:0] m);
    edge_wait(1'h1);
    flt <= m;
    repeat (4) @(posedge clk_i);
    chk("gate", 32'h0, {31'h0, gate_o});
    wait_st(3'h1, 20);
    flt <= 5'h00;
    cause(32'h1);
  endtask : mid
  task automatic results;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    results();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, 4'h0, 32'h0);
    chk("ctrl", 32'h1, rd);
    wb(1'h0, 4'h4, 32'h0);
    chk("status", 32'h0, rd);
    wb(1'h1, 4'hC, 32'hFFFFFFFF);
    wb(1'h0, 4'hC, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'h1, 4'h0, 32'h3);
    wait_st(3'h1, 20);
    wb(1'h1, 4'h0, 32'h1);
    wait_st(3'h0, 400);
    pwm_en <= 1'h1;
    edge_wait(1'h1);
    repeat (2) @(posedge clk_i);
    chk("comp", 32'h1, {31'h0, comp_sw_o});
    edge_wait(1'h0);
    repeat (2) @(posedge clk_i);
    chk("comp", 32'h0, {31'h0, comp_sw_o});
    trip(5'h01, 3, 32'h2);
    trip(5'h01, 6, 32'h2);
    trip(5'h02, 3, 32'h4);
    mid(5'h04);
    wait_st(3'h0, 400);
    mid(5'h08);
    b = rises;
    repeat (300) @(posedge clk_i);
    chk("pulses", 32'h0, rises - b);
    cool_i <= 1'h1;
    wait_st(3'h0, 400);
    cool_i <= 1'h0;
    edge_wait(1'h0);
    flt <= 5'h10;
    b = rises;
    wait_st(3'h1, 400);
    chk("pulses", 32'h3, rises - b);
    wait_st(3'h3, 400);
    b = rises;
    wait_st(3'h1, 100);
    chk("probe", 32'h1, rises - b);
    flt <= 5'h00;
    cause(32'h8);
    wait_st(3'h3, 400);
    b = rises;
    wait_st(3'h0, 100);
    chk("probe", 32'h1, rises - b);
    results();
  end
endmodule : tb_top
